// File: hw/usb_unit_pkg.sv
// Purpose: Shared constants of the USB interface unit register block
// Assumes: 32-bit peripheral accesses, registers on word offsets
// Notes:   Offsets are byte addresses within the peripheral
`default_nettype none
package usb_unit_pkg;
   // Peripheral number that selects this unit
   localparam logic [7:0]  PERIPH_ID       = 8'h01;
   // Register offsets
   localparam logic [7:0]  OFS_RESET       = 8'h00;
   localparam logic [7:0]  OFS_ADDR        = 8'h08;
   localparam logic [7:0]  OFS_FUNC        = 8'h0C;
   localparam logic [7:0]  OFS_OTG_CTL     = 8'h10;
   localparam logic [7:0]  OFS_OTG_STAT    = 8'h14;
   localparam logic [7:0]  OFS_SERIAL      = 8'h18;
   localparam logic [7:0]  OFS_FLAGS       = 8'h1C;
   localparam logic [7:0]  OFS_STICKY      = 8'h20;
   localparam logic [7:0]  OFS_PMASK       = 8'h24;
   localparam logic [7:0]  OFS_SOF         = 8'h28;
   localparam logic [7:0]  OFS_PID         = 8'h2C;
   localparam logic [7:0]  OFS_EP          = 8'h30;
   localparam logic [7:0]  OFS_EPMARK      = 8'h34;
   localparam logic [7:0]  OFS_OTGMASK     = 8'h38;
   // Reset values
   localparam logic [4:0]  FUNC_RST        = 5'h07;
   localparam logic [3:0]  SERIAL_RST      = 4'h2;
   // Flag bit positions
   localparam int          FLG_TOKEN       = 6;
   localparam int          FLG_SE0         = 5;
   localparam int          FLG_K           = 4;
   localparam int          FLG_J           = 3;
   localparam int          FLG_CRC16       = 2;
   localparam int          FLG_RXACT       = 1;
   localparam int          FLG_RXERR       = 0;
   // Flags that follow a level source when not sticky
   localparam logic [6:0]  FLAG_LEVEL_MASK = 7'h3B;
   // Line state codes
   localparam logic [1:0]  LS_SE0          = 2'h0;
   localparam logic [1:0]  LS_J            = 2'h1;
   localparam logic [1:0]  LS_K            = 2'h2;
   // Packet identifier classes and checks
   localparam logic [1:0]  PID_TOKEN_TYPE  = 2'h1;
   localparam logic [1:0]  PID_DATA_TYPE   = 2'h3;
   localparam logic [3:0]  PID_SOF         = 4'h5;
   localparam logic [2:0]  TOKEN_BYTES     = 3'h3;
   localparam logic [4:0]  CRC5_INIT       = 5'h1F;
   localparam logic [4:0]  CRC5_POLY       = 5'h05;
   localparam logic [4:0]  CRC5_RESID      = 5'h0C;
   localparam logic [15:0] CRC16_INIT      = 16'hFFFF;
   localparam logic [15:0] CRC16_POLY      = 16'h8005;
   localparam logic [15:0] CRC16_RESID     = 16'h800D;
endpackage
`default_nettype wire

// File: hw/usb_token_checker.sv
// Purpose: Checks received packets: PID, CRC5, CRC16, address match
// Assumes: Bytes arrive LSB first as whole bytes while rx_active is high
// Notes:   Verdicts are one-cycle pulses after the packet ends; pid, ep, frame follow the stored bytes
`timescale 1ns/1ns
`default_nettype none
module usb_token_checker (
   input  wire  logic        clk,
   input  wire  logic        rst,
   input  wire  logic        clr,
   input  wire  logic        rx_active,
   input  wire  logic        rx_valid,
   input  wire  logic [7:0]  rx_data,
   input  wire  logic [6:0]  dev_addr,
   output var   logic        tok_ok,
   output var   logic        sof_ok,
   output var   logic        crc16_bad,
   output var   logic        pid_ok,
   output var   logic [3:0]  pid,
   output var   logic [3:0]  ep,
   output var   logic [10:0] frame
);
   logic [2:0]  cnt_reg;   // Bytes in packet, saturates
   logic [7:0]  pid_reg;   // First byte of packet
   logic [15:0] tok_reg;   // Last two bytes
   logic [4:0]  c5_reg;    // Running CRC5
   logic [15:0] c16_reg;   // Running CRC16
   logic        act_d_reg; // Receive active, delayed

   // Serial CRC update over one byte, LSB first
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d,
                                            input logic [15:0] poly, input int top);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (d[i] ^ r[top]) begin
            r = (r << 1) ^ poly;
         end else begin
            r = r << 1;
         end
      end
      return r;
   endfunction

   wire        pkt_end  = act_d_reg & ~rx_active;
   wire        pid_good = (pid_reg[7:4] == ~pid_reg[3:0]) && (cnt_reg != 3'h0);
   wire        is_tok   = pid_good && (pid_reg[1:0] == usb_unit_pkg::PID_TOKEN_TYPE)
                          && (cnt_reg == usb_unit_pkg::TOKEN_BYTES)
                          && (c5_reg == usb_unit_pkg::CRC5_RESID);
   wire        is_sof   = pid_reg[3:0] == usb_unit_pkg::PID_SOF;
   wire        addr_hit = tok_reg[6:0] == dev_addr;
   wire [15:0] c5_wide  = crc_step({11'h000, c5_reg}, rx_data, {11'h000, usb_unit_pkg::CRC5_POLY}, 4);
   wire [15:0] c16_next = crc_step(c16_reg, rx_data, usb_unit_pkg::CRC16_POLY, 15);

   // Byte collection; count restarts whenever the receiver goes idle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg   <= 3'h0;
         pid_reg   <= 8'h00;
         tok_reg   <= 16'h0000;
         c5_reg    <= 5'h00;
         c16_reg   <= 16'h0000;
         act_d_reg <= 1'b0;
      end else if (clr) begin
         cnt_reg   <= 3'h0;
         act_d_reg <= 1'b0;
      end else begin
         act_d_reg <= rx_active;
         if (!rx_active) begin
            cnt_reg <= 3'h0;
         end else if (rx_valid && cnt_reg == 3'h0) begin
            cnt_reg <= 3'h1;
            pid_reg <= rx_data;
            c5_reg  <= usb_unit_pkg::CRC5_INIT;
            c16_reg <= usb_unit_pkg::CRC16_INIT;
         end else if (rx_valid) begin
            cnt_reg <= (cnt_reg == 3'h7) ? cnt_reg : cnt_reg + 3'h1;
            tok_reg <= {rx_data, tok_reg[15:8]};
            c5_reg  <= c5_wide[4:0];
            c16_reg <= c16_next;
         end
      end
   end

   // Verdicts at end of packet; SOF carries no address
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tok_ok    <= 1'b0;
         sof_ok    <= 1'b0;
         crc16_bad <= 1'b0;
         pid_ok    <= 1'b0;
         pid       <= 4'h0;
         ep        <= 4'h0;
         frame     <= 11'h000;
      end else begin
         tok_ok    <= ~clr & pkt_end & is_tok & ~is_sof & addr_hit;
         sof_ok    <= ~clr & pkt_end & is_tok & is_sof;
         crc16_bad <= ~clr & pkt_end & pid_good & (pid_reg[1:0] == usb_unit_pkg::PID_DATA_TYPE)
                      & (c16_reg != usb_unit_pkg::CRC16_RESID);
         pid_ok    <= ~clr & pkt_end & pid_good;
         pid       <= pid_reg[3:0];
         ep        <= tok_reg[10:7];
         frame     <= tok_reg[10:0];
      end
   end
endmodule // usb_token_checker
`default_nettype wire

// File: hw/usb_interface_unit.sv
// Purpose: Control and status registers of the USB interface unit
// Assumes: Peripheral port accesses are single-cycle, UTMI+ signals synchronous
// Notes:   Any write to the reset offset restores every register next edge, except the read answer and checker byte store
// Function
// - Forward only packets matching stored 7-bit address
// - Bits 4:2 drive OPMODE, reset one
// - Bits 1,0 drive TERMSELECT, XCVRSELECT, reset one
// - OTG control bits drive vbus and pull outputs
// - OTG status word mirrors UTMI+ status inputs
// - Serial bits 6:4 show live receive lines
// - Serial bits drive SE0, data, mode, enable_n
// - Flag 6 set on good addressed token
// - Flags 5,4,3 set on SE0, K, J
// - Flag 2 set on CRC16 failure
// - Flags 1,0 follow receive active and error
// - Non-sticky flags 6,2 clear at next packet
// - Sticky mask holds flags until one written
// - Four byte masks OR flags onto ports
// - Eleven-bit frame number from SOF, readable and writable
// - Last received PID captured, read-only
// - Last endpoint kept with valid bit 4
// - Marked endpoint delivered ORed with 0x10
// - Write to reset offset restores all state but read answer and checker bytes
`timescale 1ns/1ns
`default_nettype none
module usb_interface_unit (
   input  wire  logic        CLK_SYS,
   input  wire  logic        SYS_RST,
   input  wire  logic [7:0]  PER_NUM,
   input  wire  logic [7:0]  PER_ADDR,
   input  wire  logic        PER_WR,
   input  wire  logic        PER_RD,
   input  wire  logic [31:0] PER_WDATA,
   output logic        [31:0] PER_RDATA,
   output logic              PER_RVALID,
   input  wire  logic        UTMI_RXVALID,
   input  wire  logic        UTMI_RXACTIVE,
   input  wire  logic        UTMI_RXERROR,
   input  wire  logic [7:0]  UTMI_DATAOUT,
   input  wire  logic [1:0]  UTMI_LINESTATE,
   input  wire  logic        BVALID,
   input  wire  logic        IDGND,
   input  wire  logic        HOSTDISCONNECT,
   input  wire  logic        VBUSVALID,
   input  wire  logic        SESSVALID,
   input  wire  logic        SESSEND,
   input  wire  logic        RXRCV,
   input  wire  logic        RXDM,
   input  wire  logic        RXDP,
   output logic        [2:0] OPMODE,
   output logic              TERMSELECT,
   output logic              XCVRSELECT,
   output logic              EXTERNAL_VBUS_INDICATOR,
   output logic              DRIVE_VBUS_EXTERNAL,
   output logic              CHRGVBUS,
   output logic              DISCHRGVBUS,
   output logic              DMPULLDOWN,
   output logic              DPPULLDOWN,
   output logic              IDPULLUP,
   output logic              TXSE0,
   output logic              TXDATA,
   output logic              TXENABLE_N,
   output logic              FSLSSERIAL,
   output logic              FLAG_PORT_A,
   output logic              FLAG_PORT_B,
   output logic              FLAG_PORT_C,
   output logic              FLAG_PORT_D,
   output logic        [4:0] RX_EP_DATA,
   output logic              RX_EP_VALID
);
   // Register state
   logic [6:0]  addr_reg;      // Function address
   logic [4:0]  func_reg;      // OPMODE, TERMSELECT, XCVRSELECT
   logic [7:0]  otg_ctl_reg;   // OTG drive bits
   logic [5:0]  otg_stat_reg;  // Sampled OTG status
   logic [3:0]  serial_reg;    // Serial drive bits
   logic [6:0]  flags_reg;     // Line event flags
   logic [6:0]  sticky_reg;    // Stickiness mask
   logic [31:0] pmask_reg;     // Four port masks
   logic [10:0] sof_reg;       // Frame number from SOF
   logic [3:0]  pid_reg;       // Last PID
   logic [4:0]  ep_reg;        // Last endpoint and valid
   logic [15:0] epmark_reg;    // Endpoint marking
   logic [31:0] otgmask_reg;   // OTG status mask word
   logic [3:0]  port_reg;      // Flag port outputs
   logic [4:0]  rxep_reg;      // Delivered endpoint
   logic        rxep_vld_reg;  // Delivery strobe
   logic [31:0] rdata_reg;     // Read answer
   logic        rvld_reg;      // Read answer strobe
   logic        rxact_d_reg;   // Receive active, delayed

   // Checker results
   logic        tok_ok;
   logic        sof_ok;
   logic        crc16_bad;
   logic        pid_ok;
   logic [3:0]  tok_pid;
   logic [3:0]  tok_ep;
   logic [10:0] sof_frame;

   // Access decode; other peripheral numbers are ignored
   wire        sel       = PER_NUM == usb_unit_pkg::PERIPH_ID;
   wire        wr_hit    = sel & PER_WR;
   wire        rd_hit    = sel & PER_RD;
   wire        sw_clr    = wr_hit && PER_ADDR == usb_unit_pkg::OFS_RESET;
   wire        w_addr    = wr_hit && PER_ADDR == usb_unit_pkg::OFS_ADDR;
   wire        w_func    = wr_hit && PER_ADDR == usb_unit_pkg::OFS_FUNC;
   wire        w_otg     = wr_hit && PER_ADDR == usb_unit_pkg::OFS_OTG_CTL;
   wire        w_serial  = wr_hit && PER_ADDR == usb_unit_pkg::OFS_SERIAL;
   wire        w_flags   = wr_hit && PER_ADDR == usb_unit_pkg::OFS_FLAGS;
   wire        w_sticky  = wr_hit && PER_ADDR == usb_unit_pkg::OFS_STICKY;
   wire        w_pmask   = wr_hit && PER_ADDR == usb_unit_pkg::OFS_PMASK;
   wire        w_sof     = wr_hit && PER_ADDR == usb_unit_pkg::OFS_SOF;
   wire        w_epmark  = wr_hit && PER_ADDR == usb_unit_pkg::OFS_EPMARK;
   wire        w_otgmask = wr_hit && PER_ADDR == usb_unit_pkg::OFS_OTGMASK;
   wire [6:0]  w1c       = w_flags ? PER_WDATA[6:0] : 7'h00;
   wire        pkt_start = UTMI_RXACTIVE & ~rxact_d_reg;

   // Read multiplexer; unmapped and write-only offsets read zero
   wire [31:0] rd_word =
      (PER_ADDR == usb_unit_pkg::OFS_ADDR)     ? {25'h0000000, addr_reg} :
      (PER_ADDR == usb_unit_pkg::OFS_FUNC)     ? {27'h0000000, func_reg} :
      (PER_ADDR == usb_unit_pkg::OFS_OTG_CTL)  ? {24'h000000, otg_ctl_reg} :
      (PER_ADDR == usb_unit_pkg::OFS_OTG_STAT) ? {26'h0000000, otg_stat_reg} :
      (PER_ADDR == usb_unit_pkg::OFS_SERIAL)   ? {25'h0000000, RXRCV, RXDM, RXDP, serial_reg} :
      (PER_ADDR == usb_unit_pkg::OFS_FLAGS)    ? {25'h0000000, flags_reg} :
      (PER_ADDR == usb_unit_pkg::OFS_STICKY)   ? {25'h0000000, sticky_reg} :
      (PER_ADDR == usb_unit_pkg::OFS_PMASK)    ? pmask_reg :
      (PER_ADDR == usb_unit_pkg::OFS_SOF)      ? {21'h000000, sof_reg} :
      (PER_ADDR == usb_unit_pkg::OFS_PID)      ? {28'h0000000, pid_reg} :
      (PER_ADDR == usb_unit_pkg::OFS_EP)       ? {27'h0000000, ep_reg} :
      (PER_ADDR == usb_unit_pkg::OFS_EPMARK)   ? {16'h0000, epmark_reg} :
      (PER_ADDR == usb_unit_pkg::OFS_OTGMASK)  ? otgmask_reg : 32'h00000000;

   // Event sources per flag bit
   wire [6:0] flag_src = {tok_ok,
                          UTMI_LINESTATE == usb_unit_pkg::LS_SE0,
                          UTMI_LINESTATE == usb_unit_pkg::LS_K,
                          UTMI_LINESTATE == usb_unit_pkg::LS_J,
                          crc16_bad,
                          UTMI_RXACTIVE,
                          UTMI_RXERROR};

   // Per-flag next value; a new event always beats a clear
   logic [6:0] flag_next;
   logic [3:0] port_any;
   genvar g;
   generate
      for (g = 0; g < 7; g++) begin : g_flag
         assign flag_next[g] =
            sticky_reg[g] ? (flag_src[g] | (flags_reg[g] & ~w1c[g])) :
            usb_unit_pkg::FLAG_LEVEL_MASK[g] ? flag_src[g] :
            (flag_src[g] | (flags_reg[g] & ~w1c[g] & ~pkt_start));
      end
      for (g = 0; g < 4; g++) begin : g_port
         assign port_any[g] = |(flags_reg & pmask_reg[8*g +: 7]);
      end
   endgenerate

   usb_token_checker u_check (
      .clk       (CLK_SYS),
      .rst       (SYS_RST),
      .clr       (sw_clr),
      .rx_active (UTMI_RXACTIVE),
      .rx_valid  (UTMI_RXVALID),
      .rx_data   (UTMI_DATAOUT),
      .dev_addr  (addr_reg),
      .tok_ok    (tok_ok),
      .sof_ok    (sof_ok),
      .crc16_bad (crc16_bad),
      .pid_ok    (pid_ok),
      .pid       (tok_pid),
      .ep        (tok_ep),
      .frame     (sof_frame)
   );

   // Control registers written by software
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         addr_reg    <= 7'h00;
         func_reg    <= usb_unit_pkg::FUNC_RST;
         otg_ctl_reg <= 8'h00;
         serial_reg  <= usb_unit_pkg::SERIAL_RST;
         sticky_reg  <= 7'h00;
         pmask_reg   <= 32'h00000000;
         epmark_reg  <= 16'h0000;
         otgmask_reg <= 32'h00000000;
      end else if (sw_clr) begin
         addr_reg    <= 7'h00;
         func_reg    <= usb_unit_pkg::FUNC_RST;
         otg_ctl_reg <= 8'h00;
         serial_reg  <= usb_unit_pkg::SERIAL_RST;
         sticky_reg  <= 7'h00;
         pmask_reg   <= 32'h00000000;
         epmark_reg  <= 16'h0000;
         otgmask_reg <= 32'h00000000;
      end else begin
         if (w_addr)    addr_reg    <= PER_WDATA[6:0];
         if (w_func)    func_reg    <= PER_WDATA[4:0];
         if (w_otg)     otg_ctl_reg <= PER_WDATA[7:0] & 8'hDF;
         if (w_serial)  serial_reg  <= PER_WDATA[3:0];
         if (w_sticky)  sticky_reg  <= PER_WDATA[6:0];
         if (w_pmask)   pmask_reg   <= PER_WDATA;
         if (w_epmark)  epmark_reg  <= PER_WDATA[15:0];
         if (w_otgmask) otgmask_reg <= PER_WDATA;
      end
   end

   // Status capture: flags, OTG inputs, frame, PID, endpoint
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         flags_reg    <= 7'h00;
         otg_stat_reg <= 6'h00;
         sof_reg      <= 11'h000;
         pid_reg      <= 4'h0;
         ep_reg       <= 5'h00;
         rxact_d_reg  <= 1'b0;
      end else if (sw_clr) begin
         flags_reg    <= 7'h00;
         otg_stat_reg <= 6'h00;
         sof_reg      <= 11'h000;
         pid_reg      <= 4'h0;
         ep_reg       <= 5'h00;
         rxact_d_reg  <= 1'b0;
      end else begin
         flags_reg    <= flag_next;
         otg_stat_reg <= {BVALID, IDGND, HOSTDISCONNECT, VBUSVALID, SESSVALID, SESSEND};
         rxact_d_reg  <= UTMI_RXACTIVE;
         // A received SOF wins over a software load in the same cycle
         if (sof_ok)      sof_reg <= sof_frame;
         else if (w_sof)  sof_reg <= PER_WDATA[10:0];
         if (pid_ok)      pid_reg <= tok_pid;
         if (tok_ok)      ep_reg  <= {1'b1, tok_ep};
      end
   end

   // Port outputs and endpoint delivery, all registered
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         port_reg     <= 4'h0;
         rxep_reg     <= 5'h00;
         rxep_vld_reg <= 1'b0;
      end else if (sw_clr) begin
         port_reg     <= 4'h0;
         rxep_reg     <= 5'h00;
         rxep_vld_reg <= 1'b0;
      end else begin
         port_reg     <= port_any;
         rxep_vld_reg <= tok_ok;
         if (tok_ok)  rxep_reg <= {epmark_reg[tok_ep], tok_ep};
      end
   end

   // Read answer one cycle after the request
   always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
      if (SYS_RST) begin
         rdata_reg <= 32'h00000000;
         rvld_reg  <= 1'b0;
      end else begin
         rvld_reg  <= rd_hit;
         if (rd_hit)  rdata_reg <= rd_word;
      end
   end

   // Outputs straight from flip-flops
   assign PER_RDATA               = rdata_reg;
   assign PER_RVALID              = rvld_reg;
   assign OPMODE                  = func_reg[4:2];
   assign TERMSELECT              = func_reg[1];
   assign XCVRSELECT              = func_reg[0];
   assign EXTERNAL_VBUS_INDICATOR = otg_ctl_reg[7];
   assign DRIVE_VBUS_EXTERNAL     = otg_ctl_reg[6];
   assign CHRGVBUS                = otg_ctl_reg[4];
   assign DISCHRGVBUS             = otg_ctl_reg[3];
   assign DMPULLDOWN              = otg_ctl_reg[2];
   assign DPPULLDOWN              = otg_ctl_reg[1];
   assign IDPULLUP                = otg_ctl_reg[0];
   assign TXSE0                   = serial_reg[3];
   assign TXDATA                  = serial_reg[2];
   assign TXENABLE_N              = serial_reg[1];
   assign FSLSSERIAL              = serial_reg[0];
   assign FLAG_PORT_A             = port_reg[0];
   assign FLAG_PORT_B             = port_reg[1];
   assign FLAG_PORT_C             = port_reg[2];
   assign FLAG_PORT_D             = port_reg[3];
   assign RX_EP_DATA              = rxep_reg;
   assign RX_EP_VALID             = rxep_vld_reg;

   // Checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);

   property p_soft_reset;
      sw_clr |=> addr_reg == 7'h00 && sticky_reg == 7'h00 && TXENABLE_N;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset missed");

   property p_func_reset;
      sw_clr |=> OPMODE == 3'h1 && TERMSELECT && XCVRSELECT;
   endproperty
   a_func_reset: assert property (p_func_reset) else $error("function bits not reset");

   property p_token_flag;
      tok_ok && !sw_clr |=> flags_reg[6];
   endproperty
   a_token_flag: assert property (p_token_flag) else $error("token flag not set");

   property p_sticky_hold;
      sticky_reg[2] && flags_reg[2] && !w1c[2] && !sw_clr && !w_sticky |=> flags_reg[2];
   endproperty
   a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag lost");

   property p_rxact_follow;
      !sticky_reg[1] && !sw_clr |=> flags_reg[1] == $past(UTMI_RXACTIVE);
   endproperty
   a_rxact_follow: assert property (p_rxact_follow) else $error("rx active flag wrong");

   property p_auto_clear;
      pkt_start && !sticky_reg[6] && !tok_ok && !sw_clr |=> !flags_reg[6];
   endproperty
   a_auto_clear: assert property (p_auto_clear) else $error("flag not cleared by packet");

   property p_port_or;
      !sw_clr ##1 !sw_clr |=> FLAG_PORT_B == $past(|(flags_reg & pmask_reg[14:8]));
   endproperty
   a_port_or: assert property (p_port_or) else $error("port B mismatch");

   property p_ep_mark;
      tok_ok && !sw_clr |=> RX_EP_VALID && RX_EP_DATA[4] == $past(epmark_reg[tok_ep]) && ep_reg[4];
   endproperty
   a_ep_mark: assert property (p_ep_mark) else $error("endpoint delivery wrong");

   property p_sof_load;
      sof_ok && !sw_clr |=> sof_reg == $past(sof_frame);
   endproperty
   a_sof_load: assert property (p_sof_load) else $error("frame not loaded");

   property p_read_answer;
      rd_hit |=> PER_RVALID;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not answered");

   c_token:  cover property (tok_ok ##1 RX_EP_VALID);
   c_marked: cover property (tok_ok && epmark_reg[tok_ep]);
   c_sticky: cover property (sticky_reg[6] && flags_reg[6] && w1c[6]);
   c_crcbad: cover property (crc16_bad);
endmodule // usb_interface_unit
`default_nettype wire

// File: verification/usb_phy_model.sv
// Purpose: Receive side of the transceiver, sends whole packets
// Assumes: One byte per cycle, active one cycle ahead of data
// Notes:   Data line shows junk once a packet is over
`timescale 1ns/1ns
`default_nettype none
module usb_phy_model (
   input  wire logic       clk,
   output var  logic       rx_active,
   output var  logic       rx_valid,
   output var  logic [7:0] rx_data
);
   initial begin
      rx_active = 1'b0;
      rx_valid  = 1'b0;
      rx_data   = 8'h5A;
   end
   // Packet then idle gap, so the next one never runs into this one
   task automatic send(input logic [7:0] pkt [$]);
      @(posedge clk) rx_active <= 1'b1;
      foreach (pkt[i]) begin
         @(posedge clk) rx_valid <= 1'b1;
         rx_data <= pkt[i];
      end
      @(posedge clk) rx_active <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data;
      repeat (5) @(posedge clk);
   endtask
endmodule // usb_phy_model
`default_nettype wire

// File: verification/tb_top.sv
// Purpose: Self-checking bench of the USB interface unit
// Assumes: Tokens built here with their own CRC5
// Notes:   Delivered endpoints are queued and compared at the end
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        clk = 0, rst = 1, wr = 0, rd_s = 0, ract, rval, pa, pb, pc, pd, rv, ev, re = 0;
   logic [7:0]  ad = 0, rdat, pn = 8'h01;
   logic [31:0] wd = 0, rdata, seed = 32'h37D10B0D, v, u, w;
   logic [8:0]  st = 0;
   logic [1:0]  ls = 2'h1;
   logic [4:0]  epd, got[$], exp[$];
   logic [15:0] outs;
   int          error_cnt = 0, compares = 0;
   always #4 clk = ~clk;
   usb_phy_model usb_phy_model_inst (.clk(clk), .rx_active(ract), .rx_valid(rval), .rx_data(rdat));
   usb_interface_unit usb_interface_unit_inst (.CLK_SYS(clk), .SYS_RST(rst), .PER_NUM(pn), .PER_ADDR(ad),
      .PER_WR(wr), .PER_RD(rd_s), .PER_WDATA(wd), .PER_RDATA(rdata), .PER_RVALID(rv), .UTMI_RXVALID(rval),
      .UTMI_RXACTIVE(ract), .UTMI_RXERROR(re), .UTMI_DATAOUT(rdat), .UTMI_LINESTATE(ls), .BVALID(st[8]),
      .IDGND(st[7]), .HOSTDISCONNECT(st[6]), .VBUSVALID(st[5]), .SESSVALID(st[4]), .SESSEND(st[3]), .RXRCV(st[2]),
      .RXDM(st[1]), .RXDP(st[0]), .OPMODE(outs[15:13]), .TERMSELECT(outs[12]), .XCVRSELECT(outs[11]),
      .EXTERNAL_VBUS_INDICATOR(outs[10]), .DRIVE_VBUS_EXTERNAL(outs[9]), .CHRGVBUS(outs[8]), .DISCHRGVBUS(outs[7]),
      .DMPULLDOWN(outs[6]), .DPPULLDOWN(outs[5]), .IDPULLUP(outs[4]), .TXSE0(outs[3]), .TXDATA(outs[2]),
      .TXENABLE_N(outs[1]), .FSLSSERIAL(outs[0]), .FLAG_PORT_A(pa), .FLAG_PORT_B(pb), .FLAG_PORT_C(pc),
      .FLAG_PORT_D(pd), .RX_EP_DATA(epd), .RX_EP_VALID(ev));
   // Every delivered endpoint is kept for the final comparison
   always @(posedge clk) if (ev === 1'b1) got.push_back(epd);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Sent field is the inverted remainder, high bit first on the wire
   function automatic logic [4:0] crc5(input logic [10:0] f);
      logic [4:0] c;
      c = 5'h1F;
      for (int i = 0; i < 11; i++) c = (c[4] ^ f[i]) ? {c[3:0], 1'b0} ^ 5'h05 : {c[3:0], 1'b0};
      for (int i = 0; i < 5; i++) crc5[i] = ~c[4-i];
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) wr <= 1'b1;
      ad <= a;
      wd <= d;
      @(posedge clk) wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk) rd_s <= 1'b1;
      ad <= a;
      @(posedge clk) rd_s <= 1'b0;
      #1 chk("read valid", 32'h1, {31'h0, rv});
      chk("read data", e & m, rdata & m);
   endtask
   task automatic tok(input logic [3:0] p, input logic [10:0] f);
      usb_phy_model_inst.send('{{~p, p}, f[7:0], {crc5(f), f[10:8]}});
   endtask
   task automatic report_and_stop;
      $display("Comparisons %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Cuts a hang well past the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      report_and_stop;
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1 chk("pins", 32'h3802, outs);
      // Line idles at J, so only that flag is up after reset
      for (int i = 2; i < 16; i++) rd_reg(8'(i * 4), (i == 3) ? 7 : (i == 6) ? 2 : (i == 7) ? 8 : 0, '1);
      v = rnd();
      u = rnd();
      wr_reg(8'h08, {25'h0, v[6:0]});
      wr_reg(8'h34, {16'h0, u[15:0]});
      wr_reg(8'h24, 32'h4000_0040);
      rd_reg(8'h08, v, 32'h7F);
      // A write aimed at another peripheral number must leave the address alone
      @(posedge clk) pn <= 8'h02;
      wr_reg(8'h08, ~v);
      @(posedge clk) pn <= 8'h01;
      rd_reg(8'h08, v, 32'h7F);
      for (int i = 0; i < 4; i++) begin
         w = rnd();
         tok(4'h9, {w[3:0], v[6:0]});
         exp.push_back({u[w[3:0]], w[3:0]});
         rd_reg(8'h30, {27'h1, w[3:0]}, '1);
         rd_reg(8'h2C, 32'h9, '1);
         rd_reg(8'h1C, 32'h40, 32'h40);
         chk("flag ports", 32'h9, {pa, pb, pc, pd});
      end
      tok(4'h9, {4'h1, v[6:0] ^ 7'h01});
      rd_reg(8'h1C, 32'h0, 32'h40);
      wr_reg(8'h20, 32'h44);
      tok(4'h1, {4'h2, v[6:0]});
      exp.push_back({u[2], 4'h2});
      tok(4'h9, {4'h1, v[6:0] ^ 7'h02});
      rd_reg(8'h1C, 32'h40, 32'h40);
      wr_reg(8'h1C, 32'h40);
      rd_reg(8'h1C, 32'h0, 32'h40);
      tok(4'h5, u[26:16]);
      rd_reg(8'h28, {21'h0, u[26:16]}, '1);
      wr_reg(8'h28, {21'h0, v[31:21]});
      rd_reg(8'h28, {21'h0, v[31:21]}, '1);
      usb_phy_model_inst.send('{8'hC3, 8'h00, 8'h00, 8'h00});
      rd_reg(8'h1C, 32'h4, 32'h4);
      @(posedge clk) ls <= 2'h2;
      st <= 9'(rnd());
      re <= 1'b1;
      rd_reg(8'h1C, 32'h15, 32'h3D);
      rd_reg(8'h14, {26'h0, st[8:3]}, '1);
      rd_reg(8'h18, {25'h0, st[2:0], 4'h0}, 32'h70);
      wr_reg(8'h10, v);
      wr_reg(8'h18, u);
      wr_reg(8'h0C, w);
      chk("pins", {16'h0, w[4:0], v[7:6], v[4:0], u[3:0]}, outs);
      wr_reg(8'h00, rnd());
      chk("pins", 32'h3802, outs);
      rd_reg(8'h08, 32'h0, '1);
      chk("endpoint count", exp.size(), got.size());
      foreach (exp[i]) if (i < got.size()) chk("endpoint", exp[i], got[i]);
      report_and_stop;
   end
endmodule // tb_top
`default_nettype wire
